// File: pkg/pmbus_op_params.svh
`ifndef PMBUS_OP_PARAMS_SVH
`define PMBUS_OP_PARAMS_SVH

// Command code of the conversion-control byte
`define CONV_CTRL_CMD 8'h01
`define CONV_CTRL_RESET 8'h00
// Field positions inside the conversion-control byte
`define ON_BIT 7
`define SOFT_OFF_BIT 6
`define MARGIN_MSB 5
`define MARGIN_LSB 2
`define RESERVED_MASK 8'h03
// Margin field encodings
`define MARGIN_OFF_A 4'h0
`define MARGIN_OFF_B 4'h1
`define MARGIN_OFF_C 4'h2
`define MARGIN_LOW_IGN 4'h5
`define MARGIN_LOW_ACT 4'h6
`define MARGIN_HIGH_IGN 4'h9
`define MARGIN_HIGH_ACT 4'hA
// Bus address, arbitrary default
`define DEV_ADDR_DEFAULT 7'h2A
// Data bytes captured per block transfer
`define BLOCK_BYTES_DEFAULT 4
`define BLOCK_BYTES_MAX 4
`define BITS_PER_BYTE 4'h8
`define LAST_TX_BIT 4'h7

`endif

// File: pkg/pmbus_op_pkg.sv
package pmbus_op_pkg;

    typedef enum logic [2:0] {
        LINK_IDLE = 3'h0,
        LINK_RX = 3'h1,
        LINK_ACK = 3'h3,
        LINK_TX = 3'h2,
        LINK_TXACK = 3'h6
    } link_state_t;

    typedef enum logic [1:0] {
        SEQ_OFF = 2'h0,
        SEQ_RUN = 2'h1,
        SEQ_DELAY = 2'h3,
        SEQ_RAMP = 2'h2
    } seq_state_t;

    typedef enum logic [1:0] {
        MARGIN_NONE = 2'h0,
        MARGIN_LOW = 2'h1,
        MARGIN_HIGH = 2'h2
    } margin_t;

    typedef struct packed {
        logic [2:0] scl_q;
        logic [2:0] sda_q;
        link_state_t st;
        logic [3:0] bitcnt;
        logic [2:0] byte_idx;
        logic [7:0] sh;
        logic rw;
        logic addressed;
        logic [7:0] cmd;
        logic [31:0] blk;
        logic [2:0] wr_cnt;
        logic [7:0] op;
        logic drive_low;
        logic tx_ack;
        logic invalid;
    } link_reg_t;

    typedef struct packed {
        seq_state_t st;
        logic [23:0] cnt;
    } seq_reg_t;

endpackage

// File: design/turnoff_sequencer.sv
`timescale 1ns/1ps
`include "pmbus_op_params.svh"

module turnoff_sequencer #(
    parameter int DELAY_W = 24
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic run_req,
    input wire logic soft_off,
    input wire logic cmd_off,
    input wire logic [DELAY_W-1:0] delay_cycles,
    input wire logic vout_zero,
    output logic converting,
    output logic ramp_down,
    output logic stage_hiz
);
    generate
        if (DELAY_W < 1 || DELAY_W > 24) begin : g_bad_width
            $error("DELAY_W must be 1 to 24");
        end
    endgenerate

    pmbus_op_pkg::seq_reg_t r_r;
    pmbus_op_pkg::seq_reg_t r_nxt;

    always_comb begin
        r_nxt = r_r;
        case (r_r.st)
            pmbus_op_pkg::SEQ_OFF: begin
                if (run_req) begin
                    r_nxt.st = pmbus_op_pkg::SEQ_RUN;
                end
            end
            pmbus_op_pkg::SEQ_RUN: begin
                // Profile bit only matters at the falling edge of the request
                if (!run_req) begin
                    if (cmd_off && soft_off) begin
                        r_nxt.st = pmbus_op_pkg::SEQ_DELAY;
                        r_nxt.cnt = 24'h00_0001;
                    end else begin
                        r_nxt.st = pmbus_op_pkg::SEQ_OFF;
                    end
                end
            end
            pmbus_op_pkg::SEQ_DELAY: begin
                if (run_req) begin
                    r_nxt.st = pmbus_op_pkg::SEQ_RUN;
                end else if (r_r.cnt[DELAY_W-1:0] >= delay_cycles) begin
                    r_nxt.st = pmbus_op_pkg::SEQ_RAMP;
                end else begin
                    r_nxt.cnt = r_r.cnt + 24'h00_0001;
                end
            end
            pmbus_op_pkg::SEQ_RAMP: begin
                if (run_req) begin
                    r_nxt.st = pmbus_op_pkg::SEQ_RUN;
                end else if (vout_zero) begin
                    r_nxt.st = pmbus_op_pkg::SEQ_OFF;
                end
            end
            default: begin
                r_nxt.st = pmbus_op_pkg::SEQ_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign converting = (r_r.st != pmbus_op_pkg::SEQ_OFF);
    assign ramp_down = (r_r.st == pmbus_op_pkg::SEQ_RAMP);
    assign stage_hiz = (r_r.st == pmbus_op_pkg::SEQ_OFF);

    hard_stop_a: assert property (@(posedge clk) disable iff (reset)
        (r_r.st == pmbus_op_pkg::SEQ_RUN && !run_req && !(cmd_off && soft_off)) |=> stage_hiz)
        else $error("immediate off did not tristate the stage");
    soft_hold_a: assert property (@(posedge clk) disable iff (reset)
        (r_r.st == pmbus_op_pkg::SEQ_RUN && !run_req && cmd_off && soft_off) |=> converting && !ramp_down)
        else $error("soft off did not keep regulating");
    ramp_end_a: assert property (@(posedge clk) disable iff (reset)
        (ramp_down && !run_req && vout_zero) |=> stage_hiz)
        else $error("ramp did not stop at zero volts");
    no_self_start_a: assert property (@(posedge clk) disable iff (reset)
        (stage_hiz && !run_req) |=> stage_hiz)
        else $error("conversion started without request");
    on_ignores_profile_a: assert property (@(posedge clk) disable iff (reset)
        (converting && !ramp_down && run_req) [*2] |=> converting && !ramp_down)
        else $error("profile acted while enabled");

    soft_path_c: cover property (@(posedge clk) disable iff (reset)
        ramp_down ##1 stage_hiz);
endmodule // turnoff_sequencer

// File: design/pmbus_operation_command.sv
`timescale 1ns/1ps
`include "pmbus_op_params.svh"

// How it works
// - Block data lands lowest byte first
// - Command 01h answered by byte write/read
// - Bit 7 enables or disables conversion
// - Enable alone never starts conversion
// - Turn-off profile acts only on enable fall
// - Profile 0: stop now, stage tristated
// - Profile 1: delay, ramp down, then stop
// - Codes 0,1,2 select margin off
// - Code 5: margin low, faults ignored if bit 7 set
// - Code 6: margin low, faults acted on
// - Code 9: margin high, faults ignored if bit 7 set
// - Code A: margin high; others unsupported
// - Bits 1 and 0 read as zero
// - Unlisted write flagged as invalid data
// - Command on/off obeyed only if respected
module pmbus_operation_command #(
    parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
    parameter int BLOCK_BYTES = `BLOCK_BYTES_DEFAULT,
    parameter int DELAY_W = 24
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic cmd_respect,
    input wire logic conditions_ok,
    input wire logic [DELAY_W-1:0] toff_delay_cycles,
    input wire logic vout_at_zero,
    output logic conversion_on,
    output logic power_stage_hiz,
    output logic soft_ramp_down,
    output pmbus_op_pkg::margin_t margin_sel,
    output logic ignore_ov_uv,
    output logic invalid_data,
    output logic [7:0] conv_ctrl_value
);
    generate
        if (BLOCK_BYTES < 1 || BLOCK_BYTES > `BLOCK_BYTES_MAX) begin : g_bad_bytes
            $error("BLOCK_BYTES must be 1 to 4");
        end
    endgenerate

    function automatic logic margin_ok(input logic [3:0] m);
        margin_ok = (m == `MARGIN_OFF_A) || (m == `MARGIN_OFF_B) || (m == `MARGIN_OFF_C) ||
            (m == `MARGIN_LOW_IGN) || (m == `MARGIN_LOW_ACT) ||
            (m == `MARGIN_HIGH_IGN) || (m == `MARGIN_HIGH_ACT);
    endfunction

    function automatic logic value_ok(input logic [7:0] v);
        value_ok = ((v & `RESERVED_MASK) == 8'h00) && margin_ok(v[`MARGIN_MSB:`MARGIN_LSB]);
    endfunction

    function automatic pmbus_op_pkg::margin_t margin_of(input logic [3:0] m);
        if (m == `MARGIN_LOW_IGN || m == `MARGIN_LOW_ACT) begin
            margin_of = pmbus_op_pkg::MARGIN_LOW;
        end else if (m == `MARGIN_HIGH_IGN || m == `MARGIN_HIGH_ACT) begin
            margin_of = pmbus_op_pkg::MARGIN_HIGH;
        end else begin
            margin_of = pmbus_op_pkg::MARGIN_NONE;
        end
    endfunction

    function automatic logic margin_ignores(input logic [3:0] m);
        margin_ignores = (m == `MARGIN_LOW_IGN) || (m == `MARGIN_HIGH_IGN);
    endfunction

    pmbus_op_pkg::link_reg_t r_r;
    pmbus_op_pkg::link_reg_t r_nxt;

    // Stage 1 of each synchroniser feeds stage 2 only; edges use stages 2 and 3
    logic scl_h;
    logic scl_rise;
    logic scl_fall;
    logic sda_now;
    logic start_ev;
    logic stop_ev;
    logic [7:0] read_val;

    assign scl_h = r_r.scl_q[1];
    assign sda_now = r_r.sda_q[1];
    assign scl_rise = r_r.scl_q[1] && !r_r.scl_q[2];
    assign scl_fall = !r_r.scl_q[1] && r_r.scl_q[2];
    assign start_ev = scl_h && r_r.scl_q[2] && r_r.sda_q[2] && !sda_now;
    assign stop_ev = scl_h && r_r.scl_q[2] && !r_r.sda_q[2] && sda_now;
    // Unknown command codes are stored but never acknowledged; a read after one returns 00h
    assign read_val = (r_r.cmd == `CONV_CTRL_CMD) ? (r_r.op & ~`RESERVED_MASK) : 8'h00;

    always_comb begin
        logic ack;
        logic [2:0] k;
        ack = 1'b0;
        k = r_r.byte_idx - 3'h2;
        r_nxt = r_r;
        r_nxt.scl_q = {r_r.scl_q[1:0], scl_in};
        r_nxt.sda_q = {r_r.sda_q[1:0], sda_in};
        r_nxt.invalid = 1'b0;
        if (start_ev) begin
            r_nxt.st = pmbus_op_pkg::LINK_RX;
            r_nxt.bitcnt = 4'h0;
            r_nxt.byte_idx = 3'h0;
            r_nxt.addressed = 1'b0;
            r_nxt.wr_cnt = 3'h0;
            r_nxt.drive_low = 1'b0;
        end else if (stop_ev) begin
            // Writes commit at stop so a cut transfer never half-updates the byte
            if (r_r.addressed && r_r.cmd == `CONV_CTRL_CMD && r_r.wr_cnt != 3'h0) begin
                if (r_r.wr_cnt == 3'h1 && value_ok(r_r.blk[7:0])) begin
                    r_nxt.op = r_r.blk[7:0];
                end else begin
                    r_nxt.invalid = 1'b1;
                end
            end
            r_nxt.st = pmbus_op_pkg::LINK_IDLE;
            r_nxt.addressed = 1'b0;
            r_nxt.drive_low = 1'b0;
        end else begin
            case (r_r.st)
                pmbus_op_pkg::LINK_IDLE: begin
                    r_nxt.drive_low = 1'b0;
                end
                pmbus_op_pkg::LINK_RX: begin
                    if (scl_rise) begin
                        r_nxt.sh = {r_r.sh[6:0], sda_now};
                        r_nxt.bitcnt = r_r.bitcnt + 4'h1;
                    end else if (scl_fall && r_r.bitcnt == `BITS_PER_BYTE) begin
                        case (r_r.byte_idx)
                            3'h0: begin
                                if (r_r.sh[7:1] == DEV_ADDR) begin
                                    ack = 1'b1;
                                    r_nxt.rw = r_r.sh[0];
                                    r_nxt.addressed = ~r_r.sh[0];
                                end
                            end
                            3'h1: begin
                                r_nxt.cmd = r_r.sh;
                                ack = (r_r.sh == `CONV_CTRL_CMD);
                            end
                            default: begin
                                for (int i = 0; i < BLOCK_BYTES; i++) begin
                                    if (k == i[2:0]) begin
                                        r_nxt.blk[8*i +: 8] = r_r.sh;
                                        ack = 1'b1;
                                    end
                                end
                                if (ack) begin
                                    r_nxt.wr_cnt = r_r.wr_cnt + 3'h1;
                                end
                            end
                        endcase
                        if (ack) begin
                            r_nxt.st = pmbus_op_pkg::LINK_ACK;
                            r_nxt.drive_low = 1'b1;
                        end else begin
                            r_nxt.st = pmbus_op_pkg::LINK_IDLE;
                        end
                    end
                end
                pmbus_op_pkg::LINK_ACK: begin
                    if (scl_fall) begin
                        if (r_r.rw && r_r.byte_idx == 3'h0) begin
                            r_nxt.st = pmbus_op_pkg::LINK_TX;
                            r_nxt.sh = read_val;
                            r_nxt.bitcnt = 4'h0;
                            r_nxt.drive_low = ~read_val[7];
                        end else begin
                            r_nxt.st = pmbus_op_pkg::LINK_RX;
                            r_nxt.bitcnt = 4'h0;
                            r_nxt.drive_low = 1'b0;
                            r_nxt.byte_idx = (r_r.byte_idx == 3'h7) ? r_r.byte_idx : r_r.byte_idx + 3'h1;
                        end
                    end
                end
                pmbus_op_pkg::LINK_TX: begin
                    if (scl_fall) begin
                        if (r_r.bitcnt == `LAST_TX_BIT) begin
                            r_nxt.st = pmbus_op_pkg::LINK_TXACK;
                            r_nxt.drive_low = 1'b0;
                        end else begin
                            r_nxt.sh = {r_r.sh[6:0], 1'b0};
                            r_nxt.bitcnt = r_r.bitcnt + 4'h1;
                            r_nxt.drive_low = ~r_r.sh[6];
                        end
                    end
                end
                pmbus_op_pkg::LINK_TXACK: begin
                    if (scl_rise) begin
                        r_nxt.tx_ack = ~sda_now;
                    end else if (scl_fall) begin
                        // Host ack asks for the byte again; nack ends the read
                        if (r_r.tx_ack) begin
                            r_nxt.st = pmbus_op_pkg::LINK_TX;
                            r_nxt.sh = read_val;
                            r_nxt.bitcnt = 4'h0;
                            r_nxt.drive_low = ~read_val[7];
                        end else begin
                            r_nxt.st = pmbus_op_pkg::LINK_IDLE;
                        end
                    end
                end
                default: begin
                    r_nxt.st = pmbus_op_pkg::LINK_IDLE;
                    r_nxt.drive_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            r_r <= '0;
            r_r.scl_q <= 3'h7;
            r_r.sda_q <= 3'h7;
            r_r.op <= `CONV_CTRL_RESET;
        end else begin
            r_r <= r_nxt;
        end
    end

    logic run_req;
    logic cmd_off;

    assign run_req = conditions_ok && (!cmd_respect || r_r.op[`ON_BIT]);
    assign cmd_off = cmd_respect && !r_r.op[`ON_BIT];

    turnoff_sequencer #(
        .DELAY_W(DELAY_W)
    ) u_seq (
        .clk(clk),
        .reset(reset),
        .run_req(run_req),
        .soft_off(r_r.op[`SOFT_OFF_BIT]),
        .cmd_off(cmd_off),
        .delay_cycles(toff_delay_cycles),
        .vout_zero(vout_at_zero),
        .converting(conversion_on),
        .ramp_down(soft_ramp_down),
        .stage_hiz(power_stage_hiz)
    );

    assign sda_out = 1'b0;
    assign sda_oe = r_r.drive_low;
    assign margin_sel = margin_of(r_r.op[`MARGIN_MSB:`MARGIN_LSB]);
    assign ignore_ov_uv = r_r.op[`ON_BIT] && margin_ignores(r_r.op[`MARGIN_MSB:`MARGIN_LSB]);
    assign invalid_data = r_r.invalid;
    assign conv_ctrl_value = r_r.op & ~`RESERVED_MASK;

    reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
        r_r.op[1:0] == 2'h0 ##1 conv_ctrl_value[1:0] == 2'h0)
        else $error("reserved bits not zero");
    reject_keeps_a: assert property (@(posedge clk) disable iff (reset)
        invalid_data |-> r_r.op == $past(r_r.op))
        else $error("rejected write changed the stored byte");
    bad_write_flag_a: assert property (@(posedge clk) disable iff (reset)
        (stop_ev && r_r.addressed && r_r.cmd == `CONV_CTRL_CMD && r_r.wr_cnt == 3'h1 &&
        !value_ok(r_r.blk[7:0])) |=> invalid_data)
        else $error("unsupported data not flagged");
    margin_off_a: assert property (@(posedge clk) disable iff (reset)
        (margin_sel == pmbus_op_pkg::MARGIN_NONE) |-> r_r.op[5:2] <= 4'h2 && !ignore_ov_uv)
        else $error("margin off decode wrong");
    margin_low_a: assert property (@(posedge clk) disable iff (reset)
        (r_r.op[5:2] == `MARGIN_LOW_ACT) |-> margin_sel == pmbus_op_pkg::MARGIN_LOW && !ignore_ov_uv)
        else $error("margin low act decode wrong");
    ignore_faults_a: assert property (@(posedge clk) disable iff (reset)
        ignore_ov_uv |-> r_r.op[7] && (r_r.op[5:2] == 4'h5 || r_r.op[5:2] == 4'h9))
        else $error("fault ignore without enable and ignore code");
    cmd_disable_a: assert property (@(posedge clk) disable iff (reset)
        (cmd_respect && !r_r.op[7]) [*3] |=> !conversion_on || soft_ramp_down || u_seq.r_r.st == 2'h3)
        else $error("command off did not stop conversion");
    read_value_a: assert property (@(posedge clk) disable iff (reset)
        (r_r.st == pmbus_op_pkg::LINK_ACK && scl_fall && r_r.rw && r_r.byte_idx == 3'h0) |=>
        r_r.st == pmbus_op_pkg::LINK_TX && r_r.sh == {$past(r_r.op[7:2]), 2'h0})
        else $error("read byte loaded wrong value");

    write_ok_c: cover property (@(posedge clk) disable iff (reset)
        stop_ev && r_r.addressed && r_r.wr_cnt == 3'h1 ##1 !invalid_data);
    write_bad_c: cover property (@(posedge clk) disable iff (reset) invalid_data);
    read_done_c: cover property (@(posedge clk) disable iff (reset)
        r_r.st == pmbus_op_pkg::LINK_TXACK ##[1:200] r_r.st == pmbus_op_pkg::LINK_IDLE);
endmodule // pmbus_operation_command

// File: bench/pmbus_host_model.sv
`timescale 1ns/1ps

module pmbus_host_model #(
    parameter int HALF = 8
) (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    // SCL rests high between frames; the host only ever pulls SDA low
    initial begin
        scl = 1'h1;
        sda_pull = 1'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bit_cyc(input logic drv, output logic got);
        tick(HALF / 2);
        sda_pull <= !drv;
        tick(HALF / 2);
        scl <= 1'h1;
        tick(HALF / 2);
        got = sda;
        tick(HALF / 2);
        scl <= 1'h0;
    endtask

    task automatic start_cond();
        tick(HALF / 2);
        sda_pull <= 1'h0;
        tick(HALF / 2);
        scl <= 1'h1;
        tick(HALF / 2);
        sda_pull <= 1'h1;
        tick(HALF / 2);
        scl <= 1'h0;
    endtask

    task automatic stop_cond();
        tick(HALF / 2);
        sda_pull <= 1'h1;
        tick(HALF / 2);
        scl <= 1'h1;
        tick(HALF / 2);
        sda_pull <= 1'h0;
        tick(HALF);
    endtask

    task automatic xfer(input logic [7:0] tx, input logic ackd, output logic [7:0] rx, output logic acked);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(tx[i], rx[i]);
        end
        bit_cyc(ackd, a);
        acked = !a;
    endtask

    task automatic write_cmd(input logic [6:0] adr, input logic [7:0] cmd, input logic [7:0] d[$], output logic ok);
        logic [7:0] rx;
        logic a;
        start_cond();
        xfer({adr, 1'h0}, 1'h1, rx, ok);
        xfer(cmd, 1'h1, rx, a);
        ok = ok & a;
        foreach (d[i]) begin
            xfer(d[i], 1'h1, rx, a);
            ok = ok & a;
        end
        stop_cond();
    endtask

    task automatic read_cmd(input logic [6:0] adr, input logic [7:0] cmd, output logic [7:0] val, output logic ok);
        logic [7:0] rx;
        logic a;
        start_cond();
        xfer({adr, 1'h0}, 1'h1, rx, ok);
        xfer(cmd, 1'h1, rx, a);
        ok = ok & a;
        start_cond();
        xfer({adr, 1'h1}, 1'h1, rx, a);
        ok = ok & a;
        // Host answers the data byte with a NACK to end the read
        xfer(8'hFF, 1'h1, val, a);
        stop_cond();
    endtask
endmodule // pmbus_host_model

// File: bench/tb_top.sv
`timescale 1ns/1ps
`include "pmbus_op_params.svh"

module tb_top;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic cmd_respect = 1'h0;
    logic conditions_ok = 1'h0;
    logic vout_at_zero = 1'h0;
    logic [23:0] toff_delay_cycles = 24'h00_001E;
    logic scl, host_pull, sda_out, sda_oe, conversion_on, power_stage_hiz, soft_ramp_down, ignore_ov_uv, invalid_data;
    pmbus_op_pkg::margin_t margin_sel;
    logic [7:0] conv_ctrl_value;
    logic [7:0] stored = 8'h00;
    logic [3:0] codes[7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA};
    int error_cnt = 0;
    int check_count = 0;
    int inv_seen = 0;
    int cyc = 0;
    int seed = 32'h2184;
    // Open-drain wire with pull-up: low if either side pulls
    wire sda = !((sda_oe && !sda_out) || host_pull);

    always #2.5 clk = ~clk;

    pmbus_host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(host_pull));

    pmbus_operation_command #(.DELAY_W(24)) u_dut (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .cmd_respect(cmd_respect), .conditions_ok(conditions_ok), .toff_delay_cycles(toff_delay_cycles),
        .vout_at_zero(vout_at_zero), .conversion_on(conversion_on), .power_stage_hiz(power_stage_hiz),
        .soft_ramp_down(soft_ramp_down), .margin_sel(margin_sel), .ignore_ov_uv(ignore_ov_uv),
        .invalid_data(invalid_data), .conv_ctrl_value(conv_ctrl_value)
    );

    task automatic stop_test();
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Ceiling sits well above the roughly 40k cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (invalid_data === 1'h1) inv_seen++;
        if (cyc == 60000) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_byte(nm, {7'h00, e}, {7'h00, g});
    endtask

    task automatic do_write(input logic [7:0] b, input logic rd);
        logic ok;
        logic [7:0] rx;
        logic [7:0] q[$];
        logic [3:0] m;
        logic v;
        logic [1:0] em;
        int n0;
        n0 = inv_seen;
        m = b[5:2];
        v = (b[1:0] == 2'h0) && (m inside {4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA});
        q = {b};
        u_host.write_cmd(`DEV_ADDR_DEFAULT, `CONV_CTRL_CMD, q, ok);
        u_host.tick(8);
        chk_bit("write ack", 1'h1, ok);
        chk_byte("invalid pulses", v ? 8'h00 : 8'h01, 8'(inv_seen - n0));
        if (v) stored = b;
        m = stored[5:2];
        em = (m >= 4'h9) ? 2'h2 : ((m >= 4'h5) ? 2'h1 : 2'h0);
        chk_byte("stored", stored, conv_ctrl_value);
        chk_byte("margin", {6'h00, em}, {6'h00, margin_sel});
        chk_bit("ignore faults", stored[7] && (m == 4'h5 || m == 4'h9), ignore_ov_uv);
        if (rd) begin
            u_host.read_cmd(`DEV_ADDR_DEFAULT, `CONV_CTRL_CMD, rx, ok);
            chk_bit("read ack", 1'h1, ok);
            chk_byte("read back", stored, rx);
        end
    endtask

    initial begin
        logic ok;
        logic [7:0] q[$];
        logic [31:0] r;
        int n0;
        int i;
        repeat (16) @(posedge clk);
        reset <= 1'h0;
        u_host.tick(8);
        chk_byte("reset value", 8'h00, conv_ctrl_value);
        chk_bit("reset hiz", 1'h1, power_stage_hiz);
        chk_bit("reset on", 1'h0, conversion_on);
        // Hold time stays above the settle time of a write so the hold phase can be seen
        r = $random(seed);
        toff_delay_cycles <= {19'h0_0000, r[4:0]} + 24'h00_0014;
        foreach (codes[k]) begin
            r = $random(seed);
            do_write({r[1:0], codes[k], 2'h0}, 1'h1);
        end
        repeat (24) begin
            r = $random(seed);
            {cmd_respect, conditions_ok, vout_at_zero} <= r[10:8];
            do_write(r[7:0], 1'h1);
        end
        do_write(8'h81, 1'h1);
        q = {8'h80};
        u_host.write_cmd(`DEV_ADDR_DEFAULT, 8'h02, q, ok);
        chk_bit("cmd nack", 1'h0, ok);
        u_host.write_cmd(`DEV_ADDR_DEFAULT ^ 7'h01, `CONV_CTRL_CMD, q, ok);
        chk_bit("addr nack", 1'h0, ok);
        n0 = inv_seen;
        q = {8'h80, 8'h00};
        u_host.write_cmd(`DEV_ADDR_DEFAULT, `CONV_CTRL_CMD, q, ok);
        u_host.tick(8);
        chk_byte("block invalid", 8'h01, 8'(inv_seen - n0));
        chk_byte("block kept", stored, conv_ctrl_value);
        cmd_respect <= 1'h1;
        conditions_ok <= 1'h1;
        // Output at zero so a ramp left over from the random phase ends
        vout_at_zero <= 1'h1;
        do_write(8'h00, 1'h0);
        chk_bit("cmd off", 1'h0, conversion_on);
        do_write(8'h80, 1'h0);
        chk_bit("cmd on", 1'h1, conversion_on);
        conditions_ok <= 1'h0;
        u_host.tick(4);
        chk_bit("cond off", 1'h0, conversion_on);
        conditions_ok <= 1'h1;
        u_host.tick(4);
        chk_bit("cond on", 1'h1, conversion_on);
        do_write(8'h00, 1'h0);
        chk_bit("hard off hiz", 1'h1, power_stage_hiz);
        chk_bit("hard off ramp", 1'h0, soft_ramp_down);
        do_write(8'h80, 1'h0);
        do_write(8'hC0, 1'h0);
        chk_bit("profile held on", 1'h1, conversion_on);
        chk_bit("profile no ramp", 1'h0, soft_ramp_down);
        vout_at_zero <= 1'h0;
        do_write(8'h40, 1'h0);
        chk_bit("delay on", 1'h1, conversion_on);
        chk_bit("delay no ramp", 1'h0, soft_ramp_down);
        i = 0;
        while (soft_ramp_down !== 1'h1 && i < 80) begin
            u_host.tick(1);
            i++;
        end
        chk_bit("ramp", 1'h1, soft_ramp_down);
        chk_bit("ramp on", 1'h1, conversion_on);
        vout_at_zero <= 1'h1;
        u_host.tick(4);
        chk_bit("ramp done", 1'h0, conversion_on);
        chk_bit("ramp done hiz", 1'h1, power_stage_hiz);
        vout_at_zero <= 1'h0;
        cmd_respect <= 1'h0;
        u_host.tick(4);
        chk_bit("cmd ignored", 1'h1, conversion_on);
        stop_test();
    end
endmodule // tb_top
